/* File: core/bcs_seq.sv */
// branch/call sequencer: fetch/address/execute pipeline with two delay slots
`timescale 1ns/1ns
`include "bcs_map.svh"
module bcs_seq #(
    parameter int PC_W = `BCS_PC_W,
    parameter int ADDR_W = `BCS_ADDR_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // instruction fetch port
    output logic [ADDR_W-1:0] fetch_addr_o,
    output logic fetch_req_o,
    input wire logic fetch_ready_i,
    input wire logic [31:0] fetch_word_i,
    // decoded execute-stage operation, for the instruction now in execute
    input wire bcs_pkg::bcs_dest_t ex_dest_i,
    input wire bcs_pkg::bcs_op_t ex_op_i,
    input wire logic [PC_W-1:0] ex_src1_i,
    input wire logic [PC_W-1:0] ex_src2_i,
    input wire logic ex_cond_i,
    // pipeline view
    output logic [31:0] ex_word_o,
    output logic ex_valid_o,
    output logic [PC_W-1:0] ex_ipe_o,
    output logic [PC_W-1:0] pc_o,
    output logic glob_int_en_o,
    output logic loop_inhibit_o,
    output logic [PC_W-1:0] ret_ptr_o,
    output logic [`BCS_FLAGS_W-1:0] status_o,
    output logic [PC_W-1:0] ex_result_o,
    output logic branch_taken_o
);
    import bcs_pkg::*;

    logic [PC_W-1:0] pc_q, pc_d;
    logic [PC_W-1:0] ret_q, ret_d;
    logic [`BCS_FLAGS_W-1:0] st_q, st_d;
    logic [PC_W-1:0] fa_pc_q, fa_pc_d, ae_pc_q, ae_pc_d;
    logic [31:0] a_word_q, a_word_d, e_word_q, e_word_d;
    logic a_vld_q, a_vld_d, e_vld_q, e_vld_d;
    logic [PC_W-1:0] res_q, res_d;
    logic tk_q, tk_d;
    logic [PC_W-1:0] alu_res;
    logic [`BCS_FLAGS_W-1:0] alu_flags;
    logic adv;
    logic exec_en;
    logic is_jump;
    logic is_call;
    logic [ADDR_W-1:0] pc_inc;

    bcs_alu #(
        .W(PC_W)
    ) u_alu (
        .a_i(ex_src1_i),
        .b_i(ex_src2_i),
        .op_i(ex_op_i),
        .res_o(alu_res),
        .flags_o(alu_flags)
    );

    // a miss stalls fetch and freezes the whole pipe
    assign adv = fetch_ready_i;
    assign exec_en = adv && e_vld_q && ex_cond_i;
    assign is_jump = exec_en && (ex_dest_i == BCS_DEST_JUMP_E);
    assign is_call = exec_en && (ex_dest_i == BCS_DEST_CALL_E);
    assign pc_inc = pc_q[ADDR_W-1:0] + {{(ADDR_W-1){1'b0}}, 1'b1};

    always_comb begin
        pc_d = pc_q;
        ret_d = ret_q;
        st_d = st_q;
        fa_pc_d = fa_pc_q;
        ae_pc_d = ae_pc_q;
        a_word_d = a_word_q;
        e_word_d = e_word_q;
        a_vld_d = a_vld_q;
        e_vld_d = e_vld_q;
        res_d = res_q;
        tk_d = 1'b0;
        if (adv) begin
            // stage shift; delay-slot words already in A and at fetch are never squashed
            a_word_d = fetch_word_i;
            a_vld_d = 1'b1;
            fa_pc_d = pc_q;
            e_word_d = a_word_q;
            e_vld_d = a_vld_q;
            ae_pc_d = fa_pc_q;
            res_d = alu_res;
            // flags keep the g/l msbs of the current pc; increment only the address
            pc_d = {pc_q[PC_W-1:ADDR_W], pc_inc};
            if (is_jump || is_call) begin
                // same redirect for both codes: the target lands two fetches late
                pc_d = alu_res;
                tk_d = 1'b1;
            end
            if (is_call) begin // a plain jump never reaches the return pointer
                // pc+1 as seen now, ignoring any loop-end redirect
                ret_d = {pc_q[PC_W-1:ADDR_W], pc_inc};
            end
            if (exec_en && ex_dest_i == BCS_DEST_OTHER_E) begin
                st_d = alu_flags;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pc_q <= `BCS_PC_RESET;
            ret_q <= '0;
            st_q <= '0;
            fa_pc_q <= '0;
            ae_pc_q <= '0;
            a_word_q <= '0;
            e_word_q <= '0;
            a_vld_q <= 1'b0;
            e_vld_q <= 1'b0;
            res_q <= '0;
            tk_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            ret_q <= ret_d;
            st_q <= st_d;
            fa_pc_q <= fa_pc_d;
            ae_pc_q <= ae_pc_d;
            a_word_q <= a_word_d;
            e_word_q <= e_word_d;
            a_vld_q <= a_vld_d;
            e_vld_q <= e_vld_d;
            res_q <= res_d;
            tk_q <= tk_d;
        end
    end

    assign fetch_addr_o = pc_q[ADDR_W-1:0];
    assign fetch_req_o = 1'b1;
    assign ex_word_o = e_word_q;
    assign ex_valid_o = e_vld_q;
    assign ex_ipe_o = ae_pc_q;
    assign pc_o = pc_q;
    assign glob_int_en_o = pc_q[`BCS_G_BIT];
    assign loop_inhibit_o = pc_q[`BCS_L_BIT];
    assign ret_ptr_o = ret_q;
    assign status_o = st_q;
    assign ex_result_o = res_q;
    assign branch_taken_o = tk_q;

    a_jump_target: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (is_jump || is_call) |=> pc_q == $past(alu_res))
        else $error("pc not loaded with branch target");
    a_call_ret: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        is_call |=> ret_q[ADDR_W-1:0] == $past(pc_q[ADDR_W-1:0]) + 1'b1)
        else $error("call return pointer wrong");
    a_jump_keeps_ret: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (adv && !is_call) |=> $stable(ret_q))
        else $error("return pointer changed without call");
    a_pc_status_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (exec_en && ex_dest_i != BCS_DEST_OTHER_E) |=> $stable(st_q))
        else $error("pc-destination op changed status");
    a_seq_incr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!rst_i && adv && !is_jump && !is_call) |=>
            pc_q[ADDR_W-1:0] == $past(pc_q[ADDR_W-1:0]) + 1'b1)
        else $error("pc failed to increment");
    a_stall_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !adv |=> $stable(pc_q) && $stable(a_word_q) && $stable(e_word_q))
        else $error("pipeline moved during stall");
    a_no_annul: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!rst_i && adv) ##1 adv |=> e_word_q == $past(fetch_word_i, 2))
        else $error("fetched word did not reach execute");
    a_pipe_ipe: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!rst_i && adv) ##1 adv |=> ae_pc_q == $past(pc_q, 2))
        else $error("execute address lags wrongly");
    c_jump: cover property (@(posedge ref_clk_i) disable iff (rst_i) is_jump);
    c_call: cover property (@(posedge ref_clk_i) disable iff (rst_i) is_call);
    c_back_to_back: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        is_jump ##1 is_jump);
    c_stall: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        is_call ##1 !adv);
endmodule

/* File: inc/bcs_map.svh */
// constants for the branch/call sequencer: field positions and reset values
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
`define BCS_PC_W 32
`define BCS_G_BIT 31
`define BCS_L_BIT 30
`define BCS_ADDR_W 30
`define BCS_PC_RESET 32'h00000000
`define BCS_DEST_W 2
`define BCS_DEST_NONE 2'h0
`define BCS_DEST_JUMP 2'h1
`define BCS_DEST_CALL 2'h2
`define BCS_DEST_OTHER 2'h3
`define BCS_OP_W 4
`define BCS_FLAGS_W 4
`endif

/* File: inc/bcs_pkg.sv */
// types for the branch/call sequencer
package bcs_pkg;
    typedef enum logic [1:0] {
        BCS_DEST_NONE_E = 2'h0,
        BCS_DEST_JUMP_E = 2'h1,
        BCS_DEST_CALL_E = 2'h2,
        BCS_DEST_OTHER_E = 2'h3
    } bcs_dest_t;
    typedef enum logic [3:0] {
        BCS_OP_PASS_A = 4'h0,
        BCS_OP_PASS_B = 4'h1,
        BCS_OP_ADD = 4'h2,
        BCS_OP_SUB = 4'h3,
        BCS_OP_AND = 4'h4,
        BCS_OP_OR = 4'h5,
        BCS_OP_XOR = 4'h6,
        BCS_OP_XNOR = 4'h7,
        BCS_OP_ANDN = 4'h8,
        BCS_OP_NOT_A = 4'h9
    } bcs_op_t;
endpackage

/* File: core/bcs_alu.sv */
// two-input execute-stage function unit producing a result and status flags
`timescale 1ns/1ns
`include "bcs_map.svh"
module bcs_alu #(
    parameter int W = 32
) (
    // operands and function
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire bcs_pkg::bcs_op_t op_i,
    // result
    output logic [W-1:0] res_o,
    output logic [`BCS_FLAGS_W-1:0] flags_o
);
    import bcs_pkg::*;
    logic [W:0] sum;
    always_comb begin
        sum = '0;
        case (op_i)
            BCS_OP_PASS_A: res_o = a_i;
            BCS_OP_PASS_B: res_o = b_i;
            BCS_OP_ADD: begin
                sum = {1'b0, a_i} + {1'b0, b_i};
                res_o = sum[W-1:0];
            end
            BCS_OP_SUB: begin
                sum = {1'b0, a_i} - {1'b0, b_i};
                res_o = sum[W-1:0];
            end
            BCS_OP_AND: res_o = a_i & b_i;
            BCS_OP_OR: res_o = a_i | b_i;
            BCS_OP_XOR: res_o = a_i ^ b_i;
            BCS_OP_XNOR: res_o = ~(a_i ^ b_i);
            BCS_OP_ANDN: res_o = a_i & ~b_i;
            BCS_OP_NOT_A: res_o = ~a_i;
            default: res_o = a_i;
        endcase
        // flags: negative, carry, operand sign difference, zero
        flags_o = {res_o[W-1], sum[W], a_i[W-1] ^ b_i[W-1], res_o == '0};
    end
endmodule

/* File: verif/bcs_icache_model.sv */
// instruction cache model feeding the sequencer's fetch port
`timescale 1ns/1ns
module bcs_icache_model (
    // fetch port
    input wire logic stall_i,
    input wire logic [29:0] addr_i,
    output logic ready_o,
    output logic [31:0] word_o
);
    // a stalled line shows the inverse so stale data never looks valid
    assign ready_o = ~stall_i;
    assign word_o = stall_i ? ~{2'h3, addr_i} : {2'h3, addr_i};
endmodule

/* File: verif/tb_bcs_seq.sv */
// self-checking testbench for the branch/call sequencer
`timescale 1ns/1ns
module tb_bcs_seq;
    import bcs_pkg::*;
    logic ref_clk_i = 0;
    logic rst_i = 1;
    logic stall = 0;
    logic c = 0;
    logic rdy, req, gie, lin, bt, vld, taken;
    logic [3:0] e_st = 4'h0;
    logic [29:0] fa;
    logic [3:0] st;
    logic [31:0] wd, xw, ipe, pc, rp, res, r;
    logic [31:0] a = 0, b = 0, e_pc = 0, e_rp = 0, p1 = 0, p2 = 0, pa = 0, pb = 0;
    logic ps = 0, pcd = 0;
    bcs_dest_t d = BCS_DEST_NONE_E, pd = BCS_DEST_NONE_E;
    bcs_op_t op = BCS_OP_PASS_A, pop = BCS_OP_PASS_A;
    int fails = 0, samples_checked = 0, cyc = 0, adv = 0;

    bcs_seq i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .fetch_addr_o(fa),
        .fetch_req_o(req), .fetch_ready_i(rdy), .fetch_word_i(wd), .ex_dest_i(d),
        .ex_op_i(op), .ex_src1_i(a), .ex_src2_i(b), .ex_cond_i(c), .ex_word_o(xw),
        .ex_valid_o(vld), .ex_ipe_o(ipe), .pc_o(pc), .glob_int_en_o(gie),
        .loop_inhibit_o(lin), .ret_ptr_o(rp), .status_o(st), .ex_result_o(res),
        .branch_taken_o(bt));
    bcs_icache_model i_mem (.stall_i(stall), .addr_i(fa), .ready_o(rdy), .word_o(wd));

    always #5 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            conclude();
        end
    end

    function automatic logic [31:0] alu(bcs_op_t o, logic [31:0] x, logic [31:0] y);
        case (o)
            BCS_OP_ADD: return x + y;
            BCS_OP_SUB: return x - y;
            BCS_OP_OR: return x | y;
            BCS_OP_XOR: return x ^ y;
            default: return x;
        endcase
    endfunction

    // flag set {negative, carry, sign difference, zero}; carry only from add and subtract
    function automatic logic [3:0] flg(bcs_op_t o, logic [31:0] x, logic [31:0] y);
        logic [32:0] s;
        logic [31:0] v;
        s = '0;
        if (o == BCS_OP_ADD) s = {1'b0, x} + {1'b0, y};
        if (o == BCS_OP_SUB) s = {1'b0, x} - {1'b0, y};
        v = alu(o, x, y);
        return {v[31], s[32], x[31] ^ y[31], v == 32'h0};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // drives one cycle's execute op, then judges the edge of the previous call
    task automatic tick(input bcs_dest_t nd, input bcs_op_t no, input logic [31:0] na,
        input logic [31:0] nb, input logic nc, input logic ns);
        @(posedge ref_clk_i);
        d <= nd;
        op <= no;
        a <= na;
        b <= nb;
        c <= nc;
        stall <= ns;
        @(negedge ref_clk_i);
        if (!ps) begin
            taken = adv >= 2 && pcd && (pd == BCS_DEST_JUMP_E || pd == BCS_DEST_CALL_E);
            r = alu(pop, pa, pb);
            if (taken && pd == BCS_DEST_CALL_E) e_rp = {e_pc[31:30], e_pc[29:0] + 30'h1};
            if (adv >= 2 && pcd && pd == BCS_DEST_OTHER_E) e_st = flg(pop, pa, pb);
            p2 = p1;
            p1 = e_pc;
            e_pc = taken ? r : {e_pc[31:30], e_pc[29:0] + 30'h1};
            adv++;
            chk(bt, taken);
            if (taken) chk(res, r);
        end else begin
            chk(bt, 32'h0);
        end
        chk(fa, e_pc[29:0]);
        chk(pc, e_pc);
        chk({gie, lin}, e_pc[31:30]);
        chk(rp, e_rp);
        chk(st, e_st);
        chk({req, vld}, {1'b1, adv >= 2});
        if (adv >= 2) begin
            chk(ipe, p2);
            chk(xw, {2'h3, p2[29:0]});
        end
        pd = nd;
        pop = no;
        pa = na;
        pb = nb;
        pcd = nc;
        ps = ns;
    endtask

    task automatic idle(input int n);
        repeat (n) tick(BCS_DEST_NONE_E, BCS_OP_PASS_A, 0, 0, 0, 0);
    endtask

    task automatic t_seq();
        idle(3);
        repeat (2) tick(BCS_DEST_NONE_E, BCS_OP_PASS_A, 0, 0, 0, 1);
        idle(2);
        $display("t_seq done");
    endtask

    task automatic t_jump();
        tick(BCS_DEST_JUMP_E, BCS_OP_ADD, 32'h100, 32'h23, 1, 0);
        idle(3);
        $display("t_jump done");
    endtask

    task automatic t_call();
        tick(BCS_DEST_CALL_E, BCS_OP_OR, 32'hC0000000, 32'h200, 1, 0);
        idle(3);
        tick(BCS_DEST_CALL_E, BCS_OP_SUB, 32'h300, 32'h10, 1, 0);
        idle(3);
        $display("t_call done");
    endtask

    // back-to-back branches land in each other's delay slots
    task automatic t_slot();
        tick(BCS_DEST_JUMP_E, BCS_OP_PASS_A, 32'h400, 0, 1, 0);
        tick(BCS_DEST_JUMP_E, BCS_OP_XOR, 32'h500, 32'hF, 1, 0);
        idle(3);
        tick(BCS_DEST_JUMP_E, BCS_OP_PASS_A, 32'h600, 0, 1, 0);
        idle(1);
        tick(BCS_DEST_CALL_E, BCS_OP_PASS_A, 32'h700, 0, 1, 0);
        idle(3);
        $display("t_slot done");
    endtask

    // false condition is a no-op; a stalled branch is held, then taken once
    task automatic t_hold();
        tick(BCS_DEST_JUMP_E, BCS_OP_PASS_A, 32'h800, 0, 0, 0);
        repeat (2) tick(BCS_DEST_CALL_E, BCS_OP_PASS_A, 32'h900, 0, 1, 1);
        tick(BCS_DEST_CALL_E, BCS_OP_PASS_A, 32'h900, 0, 1, 0);
        idle(3);
        $display("t_hold done");
    endtask

    // status set by a plain op must survive a later branch and a false-condition op
    task automatic t_status();
        tick(BCS_DEST_OTHER_E, BCS_OP_ADD, 32'hFFFFFFFF, 32'h1, 1, 0);
        tick(BCS_DEST_JUMP_E, BCS_OP_SUB, 32'hA0, 32'h10, 1, 0);
        tick(BCS_DEST_OTHER_E, BCS_OP_XOR, 32'h80000000, 32'h0, 0, 0);
        idle(3);
        $display("t_status done");
    endtask

    task automatic conclude();
        $display("checked=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 0;
        t_seq();
        t_jump();
        t_call();
        t_slot();
        t_hold();
        t_status();
        conclude();
    end
endmodule
